// File: hdl/ncl_defs.svh
/*
 * Numeric constants for the configuration store, reset and lock control
 * block: register indices, field positions, codes, reset values, timing.
 * Assumes it is included by its bare name from the package; the modules use its macros.
 */
`ifndef NCL_DEFS_SVH
`define NCL_DEFS_SVH

// timing, system clock 125 MHz
`define NCL_CLK_NS 8
`define NCL_BOOT_NS 5000
`define NCL_PROG_NS 20000
`define NCL_RELOAD_NS 4000
`define NCL_BOOT_CYC ((`NCL_BOOT_NS + `NCL_CLK_NS - 1) / `NCL_CLK_NS)
`define NCL_PROG_CYC ((`NCL_PROG_NS + `NCL_CLK_NS - 1) / `NCL_CLK_NS)
`define NCL_RELOAD_CYC ((`NCL_RELOAD_NS + `NCL_CLK_NS - 1) / `NCL_CLK_NS)

// register indices
`define NCL_REG_CFG 7'h01
`define NCL_REG_TRIG 7'h02
`define NCL_REG_STATUS 7'h03
`define NCL_REG_USER 7'h04

// shared configuration fields
`define NCL_CFG_LOCK 0
`define NCL_CFG_OUT_EN 1
`define NCL_CFG_RST 2'h0
`define NCL_USER_RST 16'h0000

// trigger fields and codes
`define NCL_TRIG_RST_LSB 0
`define NCL_TRIG_BYP_LSB 4
`define NCL_TRIG_PROG 8
`define NCL_TRIG_RELOAD 9
`define NCL_RST_CODE 4'hA
`define NCL_BYP_CODE 4'h5

// status fields
`define NCL_ST_BUSY 0
`define NCL_ST_ALARM_USER 1
`define NCL_ST_ALARM_INT 2

// internal trim word, value arbitrary
`define NCL_INT_WORD 16'h5A3C

// checksum
`define NCL_CRC_POLY 16'h1021
`define NCL_CRC_INIT 16'hFFFF

// link framing
`define NCL_TGT_BASE 5'h12
`define NCL_SPI_LAST 6'h17
`define NCL_I2C_ADDR_LAST 6'h07
`define NCL_I2C_DATA_LAST 6'h20
`define NCL_I2C_ACK_LAST 6'h21
`define NCL_OUT_LAST 6'h0F
`define NCL_SPI_SLOTS 6'h18
`define NCL_I2C_SLOTS 6'h23
`define NCL_HOST_DIV 4
`define NCL_HOST_RD_DIV 8

`endif

// File: hdl/ncl_pkg.sv
/*
 * Shared types and the checksum function of the configuration store block.
 * Assumes the constants header is on the include path.
 */
`include "ncl_defs.svh"

package ncl_pkg;

    // detected serial protocol
    typedef enum logic [1:0] {
        NCL_PROTO_NONE = 2'h0,
        NCL_PROTO_SPI = 2'h1,
        NCL_PROTO_I2C = 2'h2
    } ncl_proto_t;

    // device control states
    typedef enum logic [3:0] {
        NCL_ST_BOOT = 4'h1,
        NCL_ST_IDLE = 4'h2,
        NCL_ST_PROG = 4'h4,
        NCL_ST_LOAD = 4'h8
    } ncl_state_t;

    // host sequencer states
    typedef enum logic [3:0] {
        NCL_H_WAIT = 4'h1,
        NCL_H_IDLE = 4'h2,
        NCL_H_RUN = 4'h4,
        NCL_H_GAP = 4'h8
    } ncl_hstate_t;

    // one command frame as it crosses into the system domain
    typedef struct packed {
        logic is_i2c;
        logic rd;
        logic [6:0] idx;
        logic [15:0] data;
    } ncl_cmd_t;

    // checksum over one 32-bit store image, msb first
    function automatic logic [15:0] ncl_crc16(input logic [31:0] d);
        logic [15:0] c;
        c = `NCL_CRC_INIT;
        for (int i = 31; i >= 0; i--)
        begin
            c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? `NCL_CRC_POLY : 16'h0000);
        end
        return c;
    endfunction

endpackage

// File: hdl/ncl_link_if.sv
/*
 * Pins between host and device: link clock, frame select, shared open-drain
 * data pin, open-drain serial out pin, mode pin and address select pins.
 * Assumes external pull-ups; the wire levels are resolved here.
 */
`timescale 1ns/1ps

interface ncl_link_if;
    logic link_clk;
    logic sync_n;
    logic mode_pin;
    logic [1:0] address_select_pin;
    logic data_h_o;
    logic data_h_oe;
    logic data_d_o;
    logic data_d_oe;
    logic out_pin_o;
    logic out_pin_oe;
    logic data_lvl;
    logic out_pin_lvl;

    // pulled-up wired levels
    assign data_lvl = ~((data_h_oe & ~data_h_o) | (data_d_oe & ~data_d_o));
    assign out_pin_lvl = ~(out_pin_oe & ~out_pin_o);

    modport dev (
        input link_clk, sync_n, mode_pin, address_select_pin, data_lvl,
        output data_d_o, data_d_oe, out_pin_o, out_pin_oe
    );
    modport host (
        output link_clk, sync_n, mode_pin, address_select_pin, data_h_o, data_h_oe,
        input data_lvl, out_pin_lvl
    );
endinterface

// File: hdl/ncl_device.sv
/*
 * Device end: serial front end on the link clock with protocol detection,
 * and the store, boot, reset and lock control on the system clock.
 * Assumes the host times data and frame select to the link clock it drives.
 */
`timescale 1ns/1ps

// What this block does
// - first good frame picks serial protocol
// - other protocol ignored once one is picked
// - pins serve programming only while mode low
// - target address from two address select pins
// - default serial is write-only, no readback
// - enabled out pin gives four-wire readback
// - driven pins only pull low
// - program trigger copies registers into store
// - busy flag set, accesses rejected while busy
// - reload trigger copies store into registers
// - power-on loads registers from store
// - checksum saved with store, checked only at boot load
// - two checksum alarms, set only at boot
// - user checksum fail gives factory values
// - internal checksum fail gives factory values
// - reset clears alarms, reloads user bits
// - reset only on code 1010b
// - software reset runs full boot sequence
// - no access until boot delay elapses
// - lock bit blocks config, user, program and reload writes
// - reset over I2C works while locked
// - code 0101b bypasses the lock
module ncl_device
    import ncl_pkg::*;
#(
    parameter int BOOT_CYC = `NCL_BOOT_CYC,
    parameter int PROG_CYC = `NCL_PROG_CYC,
    parameter int RELOAD_CYC = `NCL_RELOAD_CYC
) (
    // system clock and power reset
    input wire logic sys_clk,
    input wire logic resetn,
    // pins
    ncl_link_if.dev link,
    // store corruption hooks, one-cycle pulses
    input wire logic fault_user,
    input wire logic fault_int,
    // state
    output logic store_busy_flag,
    output logic user_data_crc_alarm,
    output logic internal_data_crc_alarm,
    output logic write_lock_bit,
    output logic [15:0] user_word,
    output logic [1:0] proto_latched
);

    localparam logic [31:0] FACT_WORD = {14'h0000, `NCL_CFG_RST, `NCL_USER_RST};
    localparam logic [15:0] FACT_CRC = ncl_crc16(FACT_WORD);
    localparam logic [15:0] INT_CRC = ncl_crc16({16'h0000, `NCL_INT_WORD});

    // link domain state
    logic mode_s1, mode_s2, out_en_s1, out_en_s2;
    logic [1:0] sel_s1, sel_s2;
    logic act_r, kind_r, tgl_r, data_oe_r, out_oe_r;
    logic [5:0] cnt_r;
    logic [23:0] sr_r;
    ncl_proto_t proto_r;
    ncl_cmd_t cmd_r;
    // system domain state
    ncl_state_t state_r, state_nxt;
    logic [15:0] cnt_s_r, user_r, rdw_r, store_crc_r, int_r, int_crc_r;
    logic [1:0] cfg_r;
    logic [17:0] store_r;
    logic t1_r, t2_r, t3_r, byp_r, al_u_r, al_i_r, busy_r;

    // level inputs into the link domain
    always_ff @(posedge link.link_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            {mode_s1, mode_s2, out_en_s1, out_en_s2} <= 4'h0;
            {sel_s1, sel_s2} <= 4'h0;
        end
        else
        begin
            {mode_s1, mode_s2} <= {link.mode_pin, mode_s1};
            {out_en_s1, out_en_s2} <= {cfg_r[`NCL_CFG_OUT_EN], out_en_s1};
            {sel_s1, sel_s2} <= {link.address_select_pin, sel_s1};
        end
    end

    // frame decode
    wire pins_on = ~mode_s2;
    wire spi_start = ~act_r & pins_on & ~link.sync_n & (proto_r != NCL_PROTO_I2C);
    wire i2c_start = ~act_r & pins_on & link.sync_n & ~link.data_lvl
        & (proto_r != NCL_PROTO_SPI);
    wire spi_on = act_r & ~kind_r;
    wire i2c_on = act_r & kind_r;
    wire [7:0] abyte = {sr_r[6:0], link.data_lvl};
    wire addr_hit = (abyte[7:1] == {`NCL_TGT_BASE, sel_s2}) & ~abyte[0];
    wire addr_slot = i2c_on & (cnt_r == `NCL_I2C_ADDR_LAST);
    wire spi_last = spi_on & (cnt_r == `NCL_SPI_LAST);
    wire i2c_last = i2c_on & (cnt_r == `NCL_I2C_DATA_LAST);
    wire frame_ok = pins_on & (spi_last | i2c_last);
    wire abort = ~pins_on | (spi_on & link.sync_n) | (addr_slot & ~addr_hit);
    wire stop = spi_last | (i2c_on & (cnt_r == `NCL_I2C_ACK_LAST));
    wire [3:0] out_idx = spi_start ? 4'hE : (act_r ? 4'(4'hE - cnt_r[3:0]) : 4'hF);
    wire out_slot = ~act_r | (spi_on & (cnt_r < `NCL_OUT_LAST));

    // frame sequencing
    always_ff @(posedge link.link_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            act_r <= 1'b0;
            kind_r <= 1'b0;
            cnt_r <= 6'h00;
        end
        else if (spi_start | i2c_start)
        begin
            act_r <= 1'b1;
            kind_r <= i2c_start;
            cnt_r <= spi_start ? 6'h01 : 6'h00;
        end
        else
        begin
            act_r <= act_r & ~abort & ~stop;
            cnt_r <= 6'(cnt_r + 6'h01);
        end
    end

    // shift in, hand completed frames to the system domain by toggle
    always_ff @(posedge link.link_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sr_r <= 24'h000000;
            cmd_r <= '0;
            tgl_r <= 1'b0;
            proto_r <= NCL_PROTO_NONE;
        end
        else
        begin
            sr_r <= {sr_r[22:0], link.data_lvl};
            if (frame_ok)
            begin
                cmd_r <= {kind_r, sr_r[22:0], link.data_lvl};
                tgl_r <= ~tgl_r;
                proto_r <= kind_r ? NCL_PROTO_I2C : NCL_PROTO_SPI;
            end
        end
    end

    // open-drain drivers: acknowledge slots and readback bits
    always_ff @(posedge link.link_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            data_oe_r <= 1'b0;
            out_oe_r <= 1'b0;
        end
        else
        begin
            data_oe_r <= pins_on & ((addr_slot & addr_hit) | i2c_last);
            out_oe_r <= out_en_s2 & pins_on & out_slot & ~rdw_r[out_idx];
        end
    end

    assign link.data_d_o = 1'b0;
    assign link.out_pin_o = 1'b0;
    assign link.data_d_oe = data_oe_r;
    assign link.out_pin_oe = out_oe_r;
    assign proto_latched = proto_r;

    // frame event into the system domain
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            {t1_r, t2_r, t3_r} <= 3'h0;
        else
            {t1_r, t2_r, t3_r} <= {tgl_r, t1_r, t2_r};
    end

    // command decode, command word is stable until the next frame
    wire evt = t2_r ^ t3_r;
    wire take = evt & (state_r == NCL_ST_IDLE);
    wire is_wr = take & ~cmd_r.rd;
    wire is_rd = take & cmd_r.rd;
    wire lock_eff = cfg_r[`NCL_CFG_LOCK] & ~byp_r;
    wire trig = is_wr & (cmd_r.idx == `NCL_REG_TRIG);
    wire [3:0] rst_f = cmd_r.data[`NCL_TRIG_RST_LSB +: 4];
    wire [3:0] byp_f = cmd_r.data[`NCL_TRIG_BYP_LSB +: 4];
    wire do_rst = trig & (rst_f == `NCL_RST_CODE) & (~lock_eff | cmd_r.is_i2c);
    wire do_byp = trig & (byp_f == `NCL_BYP_CODE);
    wire do_prog = trig & cmd_r.data[`NCL_TRIG_PROG] & ~lock_eff & ~do_rst;
    wire do_load = trig & cmd_r.data[`NCL_TRIG_RELOAD] & ~lock_eff & ~do_rst
        & ~cmd_r.data[`NCL_TRIG_PROG];
    wire wr_cfg = is_wr & (cmd_r.idx == `NCL_REG_CFG) & ~lock_eff;
    wire wr_user = is_wr & (cmd_r.idx == `NCL_REG_USER) & ~lock_eff;
    wire [31:0] store_word = {14'h0000, store_r};
    wire [31:0] reg_word = {14'h0000, cfg_r, user_r};
    wire user_ok = ncl_crc16(store_word) == store_crc_r;
    wire int_ok = ncl_crc16({16'h0000, int_r}) == int_crc_r;
    wire [15:0] lim = (state_r == NCL_ST_BOOT) ? 16'(BOOT_CYC) :
        ((state_r == NCL_ST_PROG) ? 16'(PROG_CYC) : 16'(RELOAD_CYC));
    wire cnt_done = cnt_s_r == 16'(lim - 16'h0001);
    wire boot_end = (state_r == NCL_ST_BOOT) & cnt_done;
    wire prog_end = (state_r == NCL_ST_PROG) & cnt_done;
    wire load_end = (state_r == NCL_ST_LOAD) & cnt_done;

    // control sequence
    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            NCL_ST_BOOT: if (cnt_done) state_nxt = NCL_ST_IDLE;
            NCL_ST_IDLE:
            begin
                if (do_rst)
                    state_nxt = NCL_ST_BOOT;
                else if (do_prog)
                    state_nxt = NCL_ST_PROG;
                else if (do_load)
                    state_nxt = NCL_ST_LOAD;
            end
            NCL_ST_PROG: if (cnt_done) state_nxt = NCL_ST_IDLE;
            NCL_ST_LOAD: if (cnt_done) state_nxt = NCL_ST_IDLE;
            default: state_nxt = NCL_ST_BOOT;
        endcase
    end

    // state, phase counter and busy flag
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_r <= NCL_ST_BOOT;
            cnt_s_r <= 16'h0000;
            busy_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_s_r <= (state_nxt != state_r) ? 16'h0000 : 16'(cnt_s_r + 16'h0001);
            busy_r <= (state_nxt == NCL_ST_PROG) | (state_nxt == NCL_ST_LOAD);
        end
    end

    // working registers
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cfg_r <= `NCL_CFG_RST;
            user_r <= `NCL_USER_RST;
        end
        else if (boot_end)
        begin
            cfg_r <= (user_ok & int_ok) ? store_r[17:16] : `NCL_CFG_RST;
            user_r <= (user_ok & int_ok) ? store_r[15:0] : `NCL_USER_RST;
        end
        else if (load_end)
            {cfg_r, user_r} <= store_r;
        else if (wr_cfg)
            cfg_r <= cmd_r.data[1:0];
        else if (wr_user)
            user_r <= cmd_r.data;
    end

    // lock bypass and checksum alarms
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            {byp_r, al_u_r, al_i_r} <= 3'h0;
        else
        begin
            if (do_rst | (wr_cfg & cmd_r.data[`NCL_CFG_LOCK]))
                byp_r <= 1'b0;
            else if (do_byp)
                byp_r <= 1'b1;
            if (do_rst)
                {al_u_r, al_i_r} <= 2'h0;
            else if (boot_end)
                {al_u_r, al_i_r} <= {~user_ok, ~int_ok};
        end
    end

    // store image with its checksums
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            store_r <= FACT_WORD[17:0];
            store_crc_r <= FACT_CRC;
            int_r <= `NCL_INT_WORD;
            int_crc_r <= INT_CRC;
        end
        else
        begin
            if (prog_end)
            begin
                store_r <= {cfg_r, user_r};
                store_crc_r <= ncl_crc16(reg_word);
            end
            else if (load_end)
                store_crc_r <= ncl_crc16(store_word);
            else if (fault_user)
                store_r[0] <= ~store_r[0];
            if (fault_int)
                int_r[0] <= ~int_r[0];
        end
    end

    // readback word, triggers read back as set only while running
    wire [15:0] trig_rd = {6'h00, state_r == NCL_ST_LOAD, state_r == NCL_ST_PROG, 8'h00};
    wire [15:0] stat_rd = {13'h0000, al_i_r, al_u_r, busy_r};
    wire [15:0] rd_mux = (cmd_r.idx == `NCL_REG_CFG) ? {14'h0000, cfg_r} :
        (cmd_r.idx == `NCL_REG_TRIG) ? trig_rd :
        (cmd_r.idx == `NCL_REG_STATUS) ? stat_rd :
        (cmd_r.idx == `NCL_REG_USER) ? user_r : 16'h0000;

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            rdw_r <= 16'h0000;
        else if (is_rd)
            rdw_r <= rd_mux;
    end

    assign store_busy_flag = busy_r;
    assign user_data_crc_alarm = al_u_r;
    assign internal_data_crc_alarm = al_i_r;
    assign write_lock_bit = cfg_r[`NCL_CFG_LOCK];
    assign user_word = user_r;
endmodule

// File: hdl/ncl_host.sv
/*
 * Host end: waits out the boot delay, then runs one command as one
 * I2C or SPI frame (two SPI frames for a read) on a divided link clock.
 * Assumes the device end and pull-ups on the open-drain pins.
 */
`timescale 1ns/1ps

module ncl_host
    import ncl_pkg::*;
#(
    parameter int BOOT_CYC = `NCL_BOOT_CYC,
    parameter int DIV = `NCL_HOST_DIV,
    parameter int RD_DIV = `NCL_HOST_RD_DIV
) (
    // system clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // pins
    ncl_link_if.host link,
    // static settings
    input wire logic prog_mode,
    input wire logic [1:0] target_sel,
    // command
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic cmd_i2c,
    input wire logic cmd_read,
    input wire logic [6:0] cmd_idx,
    input wire logic [15:0] cmd_data,
    // answer
    output logic rsp_valid,
    output logic rsp_nack,
    output logic [15:0] rsp_data
);

    ncl_hstate_t st_r, st_nxt;
    logic [15:0] hcnt_r;
    logic [5:0] slot_r;
    logic clk_r, sync_n_r, doe_r, i2c_r, rd_r, frame2_r, rdy_r, vld_r, nack_r;
    logic [23:0] pay_r;
    logic [15:0] rd_r16;
    logic [1:0] sel_r;
    logic mode_r, d1_r, d2_r, o1_r, o2_r;

    // frame image, msb first, one bit per slot
    wire [7:0] abyte = {`NCL_TGT_BASE, sel_r, 1'b0};
    wire [34:0] vec = i2c_r ? {1'b0, abyte, 1'b1, pay_r, 1'b1} : {pay_r, 11'h7FF};
    wire [5:0] nslot = 6'(slot_r + 6'h01);
    wire [5:0] last = i2c_r ? 6'(`NCL_I2C_SLOTS - 6'h01) : 6'(`NCL_SPI_SLOTS - 6'h01);
    wire [15:0] div = rd_r ? 16'(RD_DIV) : 16'(DIV);
    wire tick = hcnt_r == 16'(div - 16'h0001);
    wire low_end = (st_r == NCL_H_RUN) & ~clk_r & tick;
    wire high_end = (st_r == NCL_H_RUN) & clk_r & tick;
    wire frame_end = high_end & (slot_r == last);
    wire gap_end = (st_r == NCL_H_GAP) & (hcnt_r == 16'(4 * div - 1));
    wire again = rd_r & ~i2c_r & ~frame2_r;
    wire wait_end = (st_r == NCL_H_WAIT) & (hcnt_r == 16'(BOOT_CYC - 1));
    wire take = (st_r == NCL_H_IDLE) & cmd_valid & rdy_r;
    wire ack_slot = i2c_r & ((slot_r == 6'h09) | (slot_r == 6'h22));

    // sequencing
    always_comb
    begin
        st_nxt = st_r;
        unique case (st_r)
            NCL_H_WAIT: if (wait_end) st_nxt = NCL_H_IDLE;
            NCL_H_IDLE: if (take) st_nxt = NCL_H_RUN;
            NCL_H_RUN: if (frame_end) st_nxt = NCL_H_GAP;
            NCL_H_GAP: if (gap_end) st_nxt = again ? NCL_H_RUN : NCL_H_IDLE;
            default: st_nxt = NCL_H_WAIT;
        endcase
    end

    // state, divider and slot
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            st_r <= NCL_H_WAIT;
            hcnt_r <= 16'h0000;
            slot_r <= 6'h00;
            clk_r <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
            hcnt_r <= ((st_nxt != st_r) | tick & (st_r == NCL_H_RUN)) ? 16'h0000
                : 16'(hcnt_r + 16'h0001);
            clk_r <= (low_end | high_end) ? ~clk_r : clk_r;
            slot_r <= (st_r != NCL_H_RUN) ? 6'h00 : (high_end ? nslot : slot_r);
        end
    end

    // open-drain data, frame select, mode and address straps
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            {doe_r, sync_n_r, mode_r} <= 3'h3;
            sel_r <= 2'h0;
        end
        else
        begin
            mode_r <= ~prog_mode;
            sel_r <= target_sel;
            if (st_nxt == NCL_H_RUN & st_r != NCL_H_RUN)
                {doe_r, sync_n_r} <= take ? {cmd_i2c | ~cmd_read, cmd_i2c} : 2'h0;
            else if (frame_end)
                {doe_r, sync_n_r} <= 2'h1;
            else if (high_end)
                doe_r <= ~vec[6'(6'h22 - nslot)];
        end
    end

    // command capture
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            {i2c_r, rd_r, frame2_r, rdy_r} <= 4'h0;
            pay_r <= 24'h000000;
        end
        else
        begin
            rdy_r <= (st_nxt == NCL_H_IDLE) & ~take;
            if (take)
            begin
                {i2c_r, rd_r, frame2_r} <= {cmd_i2c, cmd_read, 1'b0};
                pay_r <= {cmd_read, cmd_idx, cmd_data};
            end
            else if (gap_end)
                frame2_r <= 1'b1;
        end
    end

    // pin inputs, two flip-flops each
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            {d1_r, d2_r, o1_r, o2_r} <= 4'hF;
        else
            {d1_r, d2_r, o1_r, o2_r} <= {link.data_lvl, d1_r, link.out_pin_lvl, o1_r};
    end

    // answer: acknowledge check and readback sampling at end of low phase
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            {vld_r, nack_r} <= 2'h0;
            rd_r16 <= 16'h0000;
        end
        else
        begin
            vld_r <= gap_end & ~again;
            if (take)
                nack_r <= 1'b0;
            else if (low_end & ack_slot & d2_r)
                nack_r <= 1'b1;
            if (low_end & frame2_r & (slot_r < 6'h10))
                rd_r16 <= {rd_r16[14:0], o2_r};
        end
    end

    assign link.link_clk = clk_r;
    assign link.sync_n = sync_n_r;
    assign link.mode_pin = mode_r;
    assign link.address_select_pin = sel_r;
    assign link.data_h_o = 1'b0;
    assign link.data_h_oe = doe_r;
    assign cmd_ready = rdy_r;
    assign rsp_valid = vld_r;
    assign rsp_nack = nack_r;
    assign rsp_data = rd_r16;
endmodule

// File: verif/ncl_link_properties.sv
/*
 * Pin-level checks on the link: open-drain polarity, ack slot timing,
 * quiet pins during boot. Assumes the bench instantiates it beside the link.
 */
`timescale 1ns/1ps

module ncl_link_properties #(
    parameter int BOOT_CYC = `NCL_BOOT_CYC
) (
    // clocks and reset
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic link_clk,
    // link pins
    input wire logic sync_n,
    input wire logic mode_pin,
    input wire logic data_h_o,
    input wire logic data_h_oe,
    input wire logic data_d_o,
    input wire logic data_d_oe,
    input wire logic out_pin_o,
    input wire logic out_pin_oe
);
    int cnt;

    // cycles since reset release, saturating
    always_ff @(posedge sys_clk or negedge resetn)
        if (!resetn)
            cnt <= 0;
        else if (cnt < BOOT_CYC)
            cnt <= cnt + 1;

    // ack is one slot wide
    sequence ack_slot;
        data_d_oe ##1 !data_d_oe;
    endsequence

    a_dev_low_only:
    assert property (@(posedge sys_clk) disable iff (!resetn) data_d_oe |-> !data_d_o)
        else $error("device data pin driven high");
    a_out_low_only:
    assert property (@(posedge sys_clk) disable iff (!resetn) out_pin_oe |-> !out_pin_o)
        else $error("out pin driven high");
    a_host_low_only:
    assert property (@(posedge sys_clk) disable iff (!resetn) data_h_oe |-> !data_h_o)
        else $error("host data pin driven high");
    a_mode_gates_pins:
    assert property (@(posedge sys_clk) disable iff (!resetn) mode_pin |-> !data_d_oe)
        else $error("device drives data while mode high");
    a_out_in_frame:
    assert property (@(posedge sys_clk) disable iff (!resetn) out_pin_oe |-> !sync_n)
        else $error("out pin driven outside serial frame");
    a_ack_i2c_only:
    assert property (@(posedge sys_clk) disable iff (!resetn) data_d_oe |-> sync_n)
        else $error("ack driven in serial frame");
    a_ack_one_slot:
    assert property (@(posedge link_clk) disable iff (!resetn) $rose(data_d_oe) |-> ack_slot)
        else $error("ack longer than one slot");
    a_boot_quiet:
    assert property (@(posedge sys_clk) disable iff (!resetn)
        (cnt < BOOT_CYC) |-> (sync_n && !link_clk))
        else $error("link active during boot");
endmodule

// File: verif/nvm_config_reset_lock_control_tb.sv
/*
 * Bench joining host and device ends; commands go through the host.
 * Assumes default boot and store times.
 */
`timescale 1ns/1ps

module nvm_config_reset_lock_control_tb;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic cmd_valid = 1'b0, prog_mode = 1'b1;
    logic cmd_i2c = 1'b1;
    logic fault_user = 1'b0;
    logic fault_int = 1'b0;
    logic [1:0] target_sel = 2'h0;
    logic [6:0] cmd_idx = 7'h00;
    logic [15:0] cmd_data = 16'h0000;
    logic cmd_ready, rsp_valid, rsp_nack, busy, alarm_u, alarm_i, lock;
    logic [15:0] rsp_data, user_word;
    logic [1:0] proto;
    int n_errors = 0;
    int check_count = 0;

    ncl_link_if link ();

    // system clock
    always #4 sys_clk = ~sys_clk;

    ncl_device ncl_device_inst (
        .sys_clk(sys_clk), .resetn(resetn), .link(link.dev), .fault_user(fault_user),
        .fault_int(fault_int), .store_busy_flag(busy), .user_data_crc_alarm(alarm_u),
        .internal_data_crc_alarm(alarm_i), .write_lock_bit(lock), .user_word(user_word),
        .proto_latched(proto));
    ncl_host ncl_host_inst (.sys_clk(sys_clk), .resetn(resetn),
        .link(link.host), .prog_mode(prog_mode), .target_sel(target_sel), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_i2c(cmd_i2c), .cmd_read(1'b0), .cmd_idx(cmd_idx),
        .cmd_data(cmd_data), .rsp_valid(rsp_valid), .rsp_nack(rsp_nack), .rsp_data(rsp_data));
    ncl_link_properties ncl_link_properties_inst (.sys_clk(sys_clk),
        .resetn(resetn), .link_clk(link.link_clk), .sync_n(link.sync_n),
        .mode_pin(link.mode_pin), .data_h_o(link.data_h_o), .data_h_oe(link.data_h_oe),
        .data_d_o(link.data_d_o), .data_d_oe(link.data_d_oe), .out_pin_o(link.out_pin_o),
        .out_pin_oe(link.out_pin_oe));

    task automatic report_and_stop();
        if (n_errors == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED %0t saw %h want %h", $time, seen, exp);
        end
    endtask

    // one bounded wait step
    task automatic tick(input int k);
        @(negedge sys_clk);
        if (k > 3000)
        begin
            n_errors++;
            $display("CHECK FAILED %0t wait ran out", $time);
            report_and_stop();
        end
    endtask

    // one write command through the host, held until taken
    task automatic cmd(input logic i2c, input logic [6:0] idx, input logic [15:0] d);
        for (int k = 0; cmd_ready !== 1'b1; k++)
            tick(k);
        cmd_valid = 1'b1;
        cmd_i2c = i2c;
        cmd_idx = idx;
        cmd_data = d;
        @(negedge sys_clk);
        cmd_valid = 1'b0;
        for (int k = 0; rsp_valid !== 1'b1; k++)
            tick(k);
    endtask

    task automatic idle_busy();
        for (int k = 0; busy !== 1'b0; k++)
            tick(k);
    endtask

    // store fault pulses, then software reset and boot
    task automatic soft_reset(input logic fu, input logic fi);
        fault_user = fu;
        fault_int = fi;
        @(negedge sys_clk);
        fault_user = 1'b0;
        fault_int = 1'b0;
        cmd(1'b1, `NCL_REG_TRIG, {12'h000, `NCL_RST_CODE});
        repeat (640) @(negedge sys_clk);
    endtask

    // main sequence
    initial
    begin
        repeat (16) @(negedge sys_clk);
        resetn = 1'b1;
        repeat (12) @(negedge sys_clk);
        check(user_word, 16'h0000);
        check({14'h0, proto}, 16'h0000);
        for (int a = 0; a < 4; a++)
        begin
            target_sel = a[1:0];
            cmd(1'b1, `NCL_REG_USER, 16'h1230 + 16'(a));
            check({15'h0, rsp_nack}, 16'h0000);
            check(user_word, 16'h1230 + 16'(a));
        end
        check({14'h0, proto}, 16'h0002);
        cmd(1'b0, `NCL_REG_USER, 16'hBEEF);
        check(user_word, 16'h1233);
        cmd(1'b1, `NCL_REG_CFG, 16'h0001);
        check({15'h0, lock}, 16'h0001);
        cmd(1'b1, `NCL_REG_USER, 16'h5555);
        check(user_word, 16'h1233);
        cmd(1'b1, `NCL_REG_TRIG, 16'h0050);
        cmd(1'b1, `NCL_REG_USER, 16'h5555);
        check(user_word, 16'h5555);
        cmd(1'b1, `NCL_REG_TRIG, 16'h0100);
        check({15'h0, busy}, 16'h0001);
        cmd(1'b1, `NCL_REG_USER, 16'h0BAD);
        check(user_word, 16'h5555);
        idle_busy();
        cmd(1'b1, `NCL_REG_USER, 16'h0BAD);
        check(user_word, 16'h0BAD);
        cmd(1'b1, `NCL_REG_TRIG, 16'h0200);
        cmd(1'b1, `NCL_REG_TRIG, 16'h0100);
        idle_busy();
        repeat (4) @(negedge sys_clk);
        check({15'h0, busy}, 16'h0000);
        check(user_word, 16'h5555);
        soft_reset(1'b0, 1'b0);
        check(user_word, 16'h5555);
        check({15'h0, lock}, 16'h0001);
        soft_reset(1'b1, 1'b0);
        check({14'h0, alarm_i, alarm_u}, 16'h0001);
        check(user_word, 16'h0000);
        cmd(1'b1, `NCL_REG_USER, 16'h0001);
        check(user_word, 16'h0001);
        soft_reset(1'b1, 1'b1);
        prog_mode = 1'b0;
        cmd(1'b1, `NCL_REG_USER, 16'h0BAD);
        check({14'h0, alarm_i, alarm_u}, 16'h0002);
        check(user_word, 16'h0000);
        report_and_stop();
    end
endmodule
